// ===== design/rds_top.sv
// Purpose: reset gathering, reset latch and delay reset timer
// Assumes: pin and brown-out inputs are asynchronous; others on core_clk
// Notes:   Timeout cycle counts are parameters so simulation can shorten them
`timescale 1ns/1ps
module rds_top #(
  parameter int CYC_SHORT = rds_pkg::CYC_SHORT,
  parameter int CYC_DEF   = rds_pkg::CYC_DEF,
  parameter int CYC_MID   = rds_pkg::CYC_MID,
  parameter int CYC_LONG  = rds_pkg::CYC_LONG
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Reset sources
  input  wire logic       external_reset_pin_n,
  input  wire logic       brown_out,
  input  wire logic       watchdog_timeout,
  input  wire logic       wake_req,
  // Configuration and power down
  input  wire logic [1:0] wake_delay_select,
  input  wire logic       sleep_clock_disable,
  input  wire logic       sleep_req,
  // Core side
  output logic            core_reset_q,
  output logic            pc_load_q,
  output logic [11:0]     reset_vector_q,
  output logic [2:0]      reset_cause_q,
  output logic            osc_run_q
);

  // ****************************************
  // Prescaler divisors, one per select value
  // ****************************************
  function automatic logic [rds_pkg::PRE_W-1:0] div_of(input int cyc);
    int d;
    d = (cyc + rds_pkg::DRT_STEPS - 1) / rds_pkg::DRT_STEPS;
    if (d < 1) begin
      d = 1;
    end
    return d[rds_pkg::PRE_W-1:0];
  endfunction

  localparam logic [rds_pkg::PRE_W-1:0] DIV_SHORT = div_of(CYC_SHORT);
  localparam logic [rds_pkg::PRE_W-1:0] DIV_DEF   = div_of(CYC_DEF);
  localparam logic [rds_pkg::PRE_W-1:0] DIV_MID   = div_of(CYC_MID);
  localparam logic [rds_pkg::PRE_W-1:0] DIV_LONG  = div_of(CYC_LONG);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic       rst_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  // ****************************************
  // Sequencer
  // ****************************************
  rds_pkg::rds_regs_t q;
  rds_pkg::rds_regs_t d;
  logic [rds_pkg::PRE_W-1:0] div_sel;
  logic                      tick;
  logic                      expired;
  logic                      hard_hold;
  logic                      soft_cause;

  always_comb begin
    case (wake_delay_select)                                 // [RULE7]
      rds_pkg::SEL_SHORT: div_sel = DIV_SHORT;               // [RULE8]
      rds_pkg::SEL_DEF:   div_sel = DIV_DEF;                 // [RULE8]
      rds_pkg::SEL_MID:   div_sel = DIV_MID;                 // [RULE8]
      default:            div_sel = DIV_LONG;                // [RULE8]
    endcase
  end

  assign tick       = (q.pre >= div_sel - 16'h0001);
  assign expired    = tick && (q.cnt == rds_pkg::DRT_TOP);   // [RULE3]
  assign hard_hold  = q.bor_f || !q.pin_f;                   // [RULE11] [RULE5]
  assign soft_cause = watchdog_timeout || wake_req;

  always_comb begin
    d         = q;
    d.pc_load = 1'b0;
    d.pin_s   = {q.pin_s[1:0], external_reset_pin_n};
    d.bor_s   = {q.bor_s[1:0], brown_out};
    if (q.pin_s[1] == q.pin_s[2]) begin
      d.pin_f = q.pin_s[2];
    end
    if (q.bor_s[1] == q.bor_s[2]) begin
      d.bor_f = q.bor_s[2];
    end
    d.pre = tick ? '0 : q.pre + 16'h0001;
    if (tick) begin
      d.cnt = q.cnt + 10'h001;
    end
    if (hard_hold) begin
      // Brown-out or pin low: latch set, timer held at zero
      d.st    = rds_pkg::RDS_HOLD;                           // [RULE12]
      d.latch = 1'b1;                                        // [RULE1]
      d.cnt   = '0;
      d.pre   = '0;
      d.pc    = rds_pkg::RESET_VEC;                          // [RULE2]
      if (q.st != rds_pkg::RDS_HOLD) begin
        d.cause = q.bor_f ? rds_pkg::RDS_C_BROWN : rds_pkg::RDS_C_PIN;
      end
    end else begin
      case (q.st)
        rds_pkg::RDS_HOLD: begin
          d.st  = rds_pkg::RDS_COUNT;                        // [RULE5]
          d.cnt = '0;
          d.pre = '0;
        end
        rds_pkg::RDS_COUNT: begin
          if (soft_cause) begin
            d.cnt   = '0;                                    // [RULE13]
            d.pre   = '0;
            d.cause = watchdog_timeout ? rds_pkg::RDS_C_WDOG : rds_pkg::RDS_C_WAKE;
          end else if (expired) begin
            d.st      = rds_pkg::RDS_RUN;
            d.latch   = 1'b0;                                // [RULE6]
            d.pc_load = 1'b1;                                // [RULE2]
            d.pc      = rds_pkg::RESET_VEC;
          end
        end
        rds_pkg::RDS_RUN: begin
          if (watchdog_timeout) begin
            d.st    = rds_pkg::RDS_COUNT;                    // [RULE1]
            d.latch = 1'b1;
            d.cnt   = '0;
            d.pre   = '0;
            d.cause = rds_pkg::RDS_C_WDOG;
          end else if (sleep_req) begin
            d.st  = rds_pkg::RDS_SLEEP;
            d.cnt = '0;
            d.pre = '0;
          end
        end
        default: begin
          // Power down: the timer measures the automatic wake delay
          if (soft_cause || expired) begin                   // [RULE7]
            d.st    = rds_pkg::RDS_COUNT;
            d.latch = 1'b1;                                  // [RULE1]
            d.cause = watchdog_timeout ? rds_pkg::RDS_C_WDOG : rds_pkg::RDS_C_WAKE;
            if (!sleep_clock_disable) begin
              // Clock kept running: minimum start-up, release next cycle
              d.cnt = rds_pkg::DRT_TOP;                      // [RULE10]
              d.pre = div_sel - 16'h0001;
            end else begin
              d.cnt = '0;
              d.pre = '0;
            end
          end
        end
      endcase
    end
    d.osc_run = !((d.st == rds_pkg::RDS_SLEEP) && sleep_clock_disable); // [RULE10]
  end

  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      q.st      <= rds_pkg::RDS_HOLD;
      q.cnt     <= '0;
      q.pre     <= '0;
      q.latch   <= 1'b1;                                     // [RULE4]
      q.pc_load <= 1'b0;
      q.pc      <= rds_pkg::RESET_VEC;
      q.cause   <= rds_pkg::RDS_C_POR;
      q.osc_run <= 1'b1;
      q.pin_s   <= rds_pkg::SYNC_RST;
      q.pin_f   <= 1'b0;
      q.bor_s   <= rds_pkg::SYNC_RST;
      q.bor_f   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign core_reset_q   = q.latch;
  assign pc_load_q      = q.pc_load;
  assign reset_vector_q = q.pc;
  assign reset_cause_q  = q.cause;
  assign osc_run_q      = q.osc_run;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_q);

  bor_hold_a: assert property (q.bor_f |=> core_reset_q && q.cnt == 10'h000) // [RULE12]
    else $error("reset not held during brown-out");
  bor_start_a: assert property ($rose(q.bor_f) |=> q.st == rds_pkg::RDS_HOLD) // [RULE11]
    else $error("brown-out did not assert reset");
  pin_low_a: assert property (!q.pin_f |=> core_reset_q && q.st == rds_pkg::RDS_HOLD) // [RULE5]
    else $error("reset pin low did not hold timer");
  release_pc_a: assert property ($fell(core_reset_q) |-> pc_load_q && reset_vector_q == 12'hFFF) // [RULE2]
    else $error("release without vector load");
  release_end_a: assert property ($fell(core_reset_q) |-> $past(q.cnt) == 10'h3FF) // [RULE6]
    else $error("release before timeout end");
  cnt_idle_a: assert property (q.st == rds_pkg::RDS_HOLD |-> q.cnt == 10'h000 && core_reset_q) // [RULE3]
    else $error("counter runs while held");
  restart_a: assert property (q.st == rds_pkg::RDS_COUNT && watchdog_timeout && !hard_hold
                              |=> q.cnt == 10'h000 && core_reset_q) // [RULE13]
    else $error("cause during count did not restart");
  osc_a: assert property (q.st == rds_pkg::RDS_SLEEP && !sleep_clock_disable |-> osc_run_q) // [RULE10]
    else $error("clock stopped in sleep");
  wdog_a: assert property (q.st == rds_pkg::RDS_RUN && watchdog_timeout |=> core_reset_q) // [RULE1]
    else $error("watchdog did not reset");
  sel_a: assert property (wake_delay_select == 2'h3 |-> div_sel == DIV_DEF) // [RULE8]
    else $error("wrong divisor for default select");

  // ****************************************
  // Input filter checks
  // ****************************************

  pin_filt_a: assert property (q.pin_s[1] == q.pin_s[2] |=> q.pin_f == $past(q.pin_s[2])) // [RULE5]
    else $error("pin filter did not follow agreeing stages");

  pin_keep_a: assert property (q.pin_s[1] != q.pin_s[2] |=> $stable(q.pin_f)) // [RULE5]
    else $error("pin filter moved on disagreeing stages");

  bor_filt_a: assert property (q.bor_s[1] == q.bor_s[2] |=> q.bor_f == $past(q.bor_s[2])) // [RULE11]
    else $error("brown-out filter did not follow agreeing stages");

  bor_keep_a: assert property (q.bor_s[1] != q.bor_s[2] |=> $stable(q.bor_f)) // [RULE12]
    else $error("brown-out filter moved on disagreeing stages");

  // ****************************************
  // Timer checks
  // ****************************************

  count_step_a: assert property (q.st == rds_pkg::RDS_COUNT && tick && !expired && // [RULE3]
                                 !soft_cause && !hard_hold |=> q.cnt == $past(q.cnt) + 10'h001)
    else $error("delay counter did not step on tick");

  count_leave_a: assert property (q.st == rds_pkg::RDS_HOLD && !hard_hold // [RULE5]
                                  |=> q.st == rds_pkg::RDS_COUNT && q.cnt == 10'h000)
    else $error("count did not start from zero after hold");

  latch_stay_a: assert property (core_reset_q && !expired |=> core_reset_q) // [RULE6]
    else $error("latch cleared before timeout end");

  sel_short_a: assert property (wake_delay_select == 2'h2 |-> div_sel == DIV_SHORT) // [RULE8]
    else $error("wrong divisor for short select");

  sel_mid_a: assert property (wake_delay_select == 2'h0 |-> div_sel == DIV_MID) // [RULE8]
    else $error("wrong divisor for middle select");

  sel_long_a: assert property (wake_delay_select == 2'h1 |-> div_sel == DIV_LONG) // [RULE8]
    else $error("wrong divisor for long select");

  // ****************************************
  // Release checks
  // ****************************************

  pc_pulse_a: assert property (pc_load_q |=> !pc_load_q) // [RULE2]
    else $error("vector load longer than one cycle");

  pc_only_a: assert property (pc_load_q |-> !core_reset_q && $past(core_reset_q)) // [RULE6]
    else $error("vector load without release");

  vec_a: assert property (reset_vector_q == 12'hFFF) // [RULE2]
    else $error("reset vector not at top of memory");

  run_free_a: assert property (q.st == rds_pkg::RDS_RUN |-> !core_reset_q) // [RULE6]
    else $error("core held while running");

  wdog_cause_a: assert property (q.st == rds_pkg::RDS_RUN && watchdog_timeout && !hard_hold // [RULE1]
                                 |=> reset_cause_q == 3'h2)
    else $error("watchdog cause not reported");

  cause_pin_a: assert property (q.st != rds_pkg::RDS_HOLD && !q.pin_f && !q.bor_f // [RULE1]
                                |=> reset_cause_q == 3'h4)
    else $error("pin cause not reported");

  cause_bor_a: assert property (q.st != rds_pkg::RDS_HOLD && q.bor_f |=> reset_cause_q == 3'h1) // [RULE11]
    else $error("brown-out cause not reported");

  // ****************************************
  // Power-down checks
  // ****************************************

  wake_set_a: assert property (q.st == rds_pkg::RDS_SLEEP && wake_req && // [RULE7]
                               !watchdog_timeout && !hard_hold
                               |=> core_reset_q && reset_cause_q == 3'h3)
    else $error("wake did not set the latch");

  sleep_wdog_a: assert property (q.st == rds_pkg::RDS_SLEEP && watchdog_timeout && !hard_hold // [RULE1]
                                 |=> core_reset_q)
    else $error("watchdog in sleep did not reset");

  fast_wake_a: assert property (q.st == rds_pkg::RDS_SLEEP && !sleep_clock_disable && // [RULE10]
                                wake_req && !hard_hold |=> q.cnt == 10'h3FF)
    else $error("clock-on wake not shortened");

  osc_off_a: assert property (q.st == rds_pkg::RDS_RUN && sleep_req && sleep_clock_disable && // [RULE10]
                              !watchdog_timeout && !hard_hold |=> !osc_run_q)
    else $error("clock not stopped in sleep");

  run_osc_a: assert property (q.st != rds_pkg::RDS_SLEEP |-> osc_run_q) // [RULE10]
    else $error("clock stopped outside sleep");

endmodule

// ===== common/rds_pkg.sv
// Purpose: constants and types for the reset delay sequencer
// Assumes: core_clk at 40 MHz
// Notes:   Operation list below
// Operation
// [RULE1] Five reset causes all initialise the core
// [RULE2] Every reset resumes execution at FFFh
// [RULE3] Ten-bit delay counter; latch holds core
// [RULE4] Power-up sets the reset latch
// [RULE5] Count starts once reset pin is high
// [RULE6] Timeout end clears latch; default 18 ms
// [RULE7] Two-bit select sets delay and wake delay
// [RULE8] Select: 10=0.25ms 11=18ms 00=60ms 01=1s
// [RULE9] Software: fast wake uses clock on, 00
// [RULE10] Clock keeps running in sleep when enabled
// [RULE11] Brown-out indication asserts reset
// [RULE12] Reset held while brown-out persists
// [RULE13] New cause while counting restarts count
package rds_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_SHORT_NS    = 250000;
  localparam int T_DEF_NS      = 18000000;
  localparam int T_MID_NS      = 60000000;
  localparam int T_LONG_NS     = 1000000000;
  localparam int CYC_SHORT     = (T_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_DEF       = (T_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_MID       = (T_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_LONG      = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Widths, encodings and reset values
  // ****************************************
  localparam int             DRT_W      = 10;
  localparam int             DRT_STEPS  = 1024;
  localparam int             PRE_W      = 16;
  localparam logic [9:0]     DRT_TOP    = 10'h3FF;
  localparam logic [11:0]    RESET_VEC  = 12'hFFF;
  localparam logic [1:0]     SEL_SHORT  = 2'h2;
  localparam logic [1:0]     SEL_DEF    = 2'h3;
  localparam logic [1:0]     SEL_MID    = 2'h0;
  localparam logic [1:0]     SEL_LONG   = 2'h1;
  localparam logic [2:0]     SYNC_RST   = 3'h0;

  typedef enum logic [1:0] {
    RDS_HOLD  = 2'b00,
    RDS_COUNT = 2'b01,
    RDS_RUN   = 2'b10,
    RDS_SLEEP = 2'b11
  } rds_state_t;

  typedef enum logic [2:0] {
    RDS_C_POR   = 3'b000,
    RDS_C_BROWN = 3'b001,
    RDS_C_WDOG  = 3'b010,
    RDS_C_WAKE  = 3'b011,
    RDS_C_PIN   = 3'b100
  } rds_cause_t;

  typedef struct packed {
    rds_state_t         st;
    logic [DRT_W-1:0]   cnt;
    logic [PRE_W-1:0]   pre;
    logic               latch;
    logic               pc_load;
    logic [11:0]        pc;
    rds_cause_t         cause;
    logic               osc_run;
    logic [2:0]         pin_s;
    logic               pin_f;
    logic [2:0]         bor_s;
    logic               bor_f;
  } rds_regs_t;

endpackage

// ===== dv/rds_ext_model.sv
// Purpose: model of the external reset pin and the supply monitor
// Assumes: the pin has a pull-up; levels change just after the clock edge
// Notes:   the bench asks for the pin to be pulled low or for a supply dip
`timescale 1ns/1ps
module rds_ext_model (
  // Clock and bench requests
  input  wire logic core_clk,
  input  wire logic pin_low,
  input  wire logic bor_on,
  // Device pins
  output logic      external_reset_pin_n,
  output logic      brown_out
);
  initial begin
    external_reset_pin_n = 1'b0;
    brown_out            = 1'b0;
  end
  // Pin pulled low on request, otherwise held high by the pull-up
  always @(posedge core_clk) begin
    external_reset_pin_n <= ~pin_low;
    brown_out            <= bor_on;
  end
endmodule

// ===== dv/rds_top_tb.sv
// Purpose: self-checking bench for the reset delay sequencer
// Assumes: periods shortened to 1024..4096 cycles, prescaler 1..4
// Notes:   outputs are sampled at the falling edge
`timescale 1ns/1ps
module rds_top_tb;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin_low = 1'b1;
  logic        bor_on = 1'b0;
  logic        watchdog_timeout = 1'b0;
  logic        wake_req = 1'b0;
  logic [1:0]  wake_delay_select = 2'h3;
  logic        sleep_clock_disable = 1'b1;
  logic        sleep_req = 1'b0;
  logic        pin_n;
  logic        brown;
  logic        core_reset_q;
  logic        pc_load_q;
  logic        osc_run_q;
  logic [11:0] reset_vector_q;
  logic [2:0]  reset_cause_q;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  rds_ext_model ext_u (.core_clk(core_clk), .pin_low(pin_low), .bor_on(bor_on),
    .external_reset_pin_n(pin_n), .brown_out(brown));
  rds_top #(.CYC_SHORT(1024), .CYC_DEF(2048), .CYC_MID(3072), .CYC_LONG(4096)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .external_reset_pin_n(pin_n),
    .brown_out(brown), .watchdog_timeout(watchdog_timeout), .wake_req(wake_req),
    .wake_delay_select(wake_delay_select), .sleep_clock_disable(sleep_clock_disable),
    .sleep_req(sleep_req), .core_reset_q(core_reset_q), .pc_load_q(pc_load_q),
    .reset_vector_q(reset_vector_q), .reset_cause_q(reset_cause_q), .osc_run_q(osc_run_q));
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One-cycle pulse: 0 watchdog, 1 wake, 2 sleep
  task automatic pulse(int k);
    @(posedge core_clk);
    case (k)
      0: watchdog_timeout <= 1'b1;
      1: wake_req <= 1'b1;
      default: sleep_req <= 1'b1;
    endcase
    @(posedge core_clk);
    watchdog_timeout <= 1'b0;
    wake_req <= 1'b0;
    sleep_req <= 1'b0;
  endtask
  task automatic wait_set(logic [2:0] cause);
    int n;
    n = 0;
    tick(1);
    while (core_reset_q !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    chk(16'(core_reset_q), 16'h1);
    chk(16'(reset_cause_q), 16'(cause));
  endtask
  // Cycles until release must fall in lo..hi; then the load pulse
  task automatic rel(int lo, int hi);
    int n;
    n = 0;
    while (core_reset_q !== 1'b0 && n < 6000) begin
      tick(1);
      n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h1);
    chk(16'(pc_load_q), 16'h1);
    chk(16'(reset_vector_q), 16'hFFF);
    tick(1);
    chk(16'(pc_load_q), 16'h0);
  endtask
  task automatic t_power();
    repeat (4) @(posedge core_clk);
    chk(16'({core_reset_q, reset_cause_q, osc_run_q}), 16'h11);
    rst_b <= 1'b1;
    tick(100);
    chk(16'(core_reset_q), 16'h1);
    @(posedge core_clk);
    pin_low <= 1'b0;
    rel(2048, 2060);
    $display("power-up test done");
  endtask
  task automatic t_select();
    logic [1:0] codes[4];
    codes = '{2'h2, 2'h3, 2'h0, 2'h1};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      wake_delay_select <= codes[i];
      pulse(0);
      wait_set(3'h2);
      rel(1024 * (i + 1) - 4, 1024 * (i + 1) + 12);
    end
    $display("select test done");
  endtask
  task automatic t_restart();
    @(posedge core_clk);
    wake_delay_select <= 2'h2;
    pulse(0);
    tick(500);
    pulse(0);
    wait_set(3'h2);
    rel(1020, 1036);
    $display("restart test done");
  endtask
  task automatic t_brown_pin();
    @(posedge core_clk);
    bor_on <= 1'b1;
    wait_set(3'h1);
    tick(3000);
    chk(16'(core_reset_q), 16'h1);
    @(posedge core_clk);
    bor_on <= 1'b0;
    rel(1024, 1044);
    @(posedge core_clk);
    pin_low <= 1'b1;
    wait_set(3'h4);
    @(posedge core_clk);
    pin_low <= 1'b0;
    rel(1024, 1044);
    $display("brown-out and pin test done");
  endtask
  task automatic t_sleep();
    pulse(2);
    tick(2);
    chk(16'(osc_run_q), 16'h0);
    pulse(1);
    wait_set(3'h3);
    rel(1016, 1036);
    pulse(2);
    tick(1016);
    chk(16'(core_reset_q), 16'h0);
    wait_set(3'h3);
    rel(1016, 1036);
    @(posedge core_clk);
    sleep_clock_disable <= 1'b0;
    wake_delay_select <= 2'h0;
    pulse(2);
    tick(2);
    chk(16'(osc_run_q), 16'h1);
    @(posedge core_clk);
    wake_req <= 1'b1;
    @(posedge core_clk);
    wake_req <= 1'b0;
    tick(1);
    chk(16'(core_reset_q), 16'h1);
    chk(16'(reset_cause_q), 16'h3);
    rel(0, 10);
    $display("sleep test done");
  endtask
  initial begin
    #(25 * 60000);
    $display("ERROR %0t watchdog expired", $time);
    miscompares++;
    finish_test();
  end
  initial begin
    t_power();
    t_select();
    t_restart();
    t_brown_pin();
    t_sleep();
    finish_test();
  end
endmodule
